// >>> verif/delay_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module delay_port_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic serial_protocol_select,
	input wire logic sck_scl,
	input wire logic sdi_addr_select_high,
	input wire logic cs_n_addr_select_low,
	input wire logic sdo_sda_in,
	input wire logic sdo_sda_out,
	input wire logic sdo_sda_oe,
	input wire delay_port_pkg::code_t red_channel_delay,
	input wire delay_port_pkg::code_t green_channel_delay,
	input wire delay_port_pkg::code_t blue_channel_delay
);
	// Run lengths of raw pin levels; age counts clocks since the serial clock rose
	logic [3:0] spi_r, i2c_r, csl_r, csh_r, age_r, spi_nxt, i2c_nxt, csl_nxt, csh_nxt, age_nxt;
	logic sck_r, spi_on, i2c_on;
	logic [17:0] codes;
	assign codes = {red_channel_delay, green_channel_delay, blue_channel_delay};
	assign spi_on = spi_r > 4'h5;
	assign i2c_on = i2c_r > 4'h8;
	function automatic logic [3:0] run(input logic on, input logic [3:0] n);
		return on ? n + {3'h0, n != 4'hF} : 4'h0;
	endfunction
	always_comb begin
		spi_nxt = run(serial_protocol_select, spi_r);
		i2c_nxt = run(!serial_protocol_select, i2c_r);
		csl_nxt = run(!cs_n_addr_select_low, csl_r);
		csh_nxt = run(cs_n_addr_select_low, csh_r);
		age_nxt = (sck_scl && !sck_r) ? 4'h0 : run(1'b1, age_r);
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			{spi_r, i2c_r, csl_r, csh_r} <= '0;
			age_r <= 4'hF;
			sck_r <= 1'b1;
		end else begin
			{spi_r, i2c_r, csl_r, csh_r} <= {spi_nxt, i2c_nxt, csl_nxt, csh_nxt};
			age_r <= age_nxt;
			sck_r <= sck_scl;
		end
	end
	default clocking cb @(posedge clk); endclocking
	// A frozen block answers nothing, so nothing is judged while ce is low
	default disable iff (rst || !ce);
	chk_spi_drive_on: assert property (spi_on && csl_r > 4'h5 |-> sdo_sda_oe)
		else $error("sdo idle while selected");
	chk_spi_drive_off: assert property (spi_on && csh_r > 4'h5 |-> !sdo_sda_oe)
		else $error("sdo driven while deselected");
	chk_sdo_after_rise: assert property (spi_on && csl_r > 4'h9 && $changed(sdo_sda_out) |-> age_r < 4'h8)
		else $error("sdo moved away from a rising edge");
	chk_code_after_rise: assert property ($changed(codes) |-> age_r < 4'h9)
		else $error("code changed away from a clock edge");
	chk_spi_idle_hold: assert property (spi_on && csh_r > 4'h9 |-> $stable(codes))
		else $error("code changed while deselected");
	chk_i2c_open_drain: assert property (i2c_on |-> !sdo_sda_out)
		else $error("sda driven high");
	chk_i2c_pull_low: assert property (i2c_on && $rose(sdo_sda_oe) |-> !$past(sck_scl, 2))
		else $error("sda pulled while scl high");
	chk_i2c_release: assert property (i2c_on && $fell(sdo_sda_oe) |-> !$past(sck_scl, 2))
		else $error("sda released while scl high");
endmodule // delay_port_chk
bind dual_serial_delay_code_port delay_port_chk chk_i (.clk(clk), .rst(rst), .ce(ce),
	.serial_protocol_select(serial_protocol_select), .sck_scl(sck_scl),
	.sdi_addr_select_high(sdi_addr_select_high), .cs_n_addr_select_low(cs_n_addr_select_low),
	.sdo_sda_in(sdo_sda_in), .sdo_sda_out(sdo_sda_out), .sdo_sda_oe(sdo_sda_oe),
	.red_channel_delay(red_channel_delay), .green_channel_delay(green_channel_delay),
	.blue_channel_delay(blue_channel_delay));
`default_nettype wire

// >>> verif/dual_serial_delay_code_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dual_serial_delay_code_port_bench;
	logic clk, rst, ce, sps, sck, a1, a0, pull, out, oe, line;
	delay_port_pkg::code_t red, green, blue;
	logic [17:0] codes, exp;
	logic [5:0] val [3] = '{6'h2A, 6'h15, 6'h3F};
	int miscompares, compares;
	// Pull-up wire; the device drives it outright in SPI mode
	assign line = oe ? out : !pull;
	assign codes = {red, green, blue};
	dual_serial_delay_code_port dut (.clk(clk), .rst(rst), .ce(ce), .serial_protocol_select(sps),
		.sck_scl(sck), .sdi_addr_select_high(a1), .cs_n_addr_select_low(a0), .sdo_sda_in(line),
		.sdo_sda_out(out), .sdo_sda_oe(oe), .red_channel_delay(red),
		.green_channel_delay(green), .blue_channel_delay(blue));
	serial_host_model host (.clk(clk), .line(line), .sclk(sck), .mosi_a1(a1), .sel_a0(a0),
		.pull(pull));
	task automatic cmp(input string what, input logic [17:0] e, input logic [17:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic t_spi();
		logic [15:0] rx;
		for (int c = 0; c < 3; c++) begin
			host.spi({8'(c), 2'h3, val[c]}, 16, rx);
			exp[17 - 6 * c -: 6] = val[c];
			cmp("spi write", exp, codes);
			host.spi({8'h80 | 8'(c), 8'h00}, 16, rx);
			cmp("spi read", 18'(val[c]), 18'(rx[5:0]));
		end
	endtask
	task automatic t_refuse();
		logic [15:0] rx;
		host.spi(16'h003F, 12, rx);
		cmp("short frame", exp, codes);
		host.spi(16'h0007, 16, rx);
		exp[17:12] = 6'h07;
		cmp("frame after short", exp, codes);
		host.spi(16'h0315, 16, rx);
		cmp("unused select write", exp, codes);
		host.spi(16'h8300, 16, rx);
		cmp("unused select read", 18'h0, 18'(rx[5:0]));
	endtask
	// A whole frame sent while the block is frozen must leave no trace
	task automatic t_freeze();
		logic [15:0] rx;
		ce = 1'b0;
		host.spi(16'h012A, 16, rx);
		ce = 1'b1;
		cmp("frozen write", exp, codes);
		host.spi(16'h8100, 16, rx);
		cmp("read after freeze", 18'(val[1]), 18'(rx[5:0]));
	endtask
	task automatic t_i2c();
		logic [15:0] rx;
		logic [7:0] d;
		logic [5:0] v;
		logic [2:0] nak;
		sps = 1'b0;
		host.pins(1'b0, 1'b0);
		host.spi(16'h0101, 16, rx);
		cmp("spi in i2c mode", exp, codes);
		for (int a = 0; a < 4; a++) begin
			v = 6'(a * 13 + 5);
			host.pins(a[1], a[0]);
			host.i2c_wr(7'h38 | 7'(a ^ 1), 8'h00, 8'h11, nak);
			cmp("foreign nak", 18'h7, 18'(nak));
			cmp("foreign write", exp, codes);
			host.i2c_wr(7'h38 | 7'(a), 8'(a % 3), {2'h0, v}, nak);
			exp[17 - 6 * (a % 3) -: 6] = v;
			cmp("write nak", 18'h0, 18'(nak));
			cmp("i2c write", exp, codes);
			host.i2c_rd(7'h38 | 7'(a), 8'(a % 3), d, nak);
			cmp("read nak", 18'h0, 18'(nak));
			cmp("i2c read", 18'(v), 18'(d));
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		sps = 1'b1;
		exp = '0;
		miscompares = 0;
		compares = 0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (6) @(negedge clk);
		cmp("reset codes", exp, codes);
		t_spi();
		t_refuse();
		t_freeze();
		t_i2c();
		print_verdict();
	end
endmodule // dual_serial_delay_code_port_bench
`default_nettype wire

// >>> verif/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
	input wire logic clk,
	input wire logic line,
	output logic sclk,
	output logic mosi_a1,
	output logic sel_a0,
	output logic pull
);
	initial begin
		sclk = 1'b0;
		mosi_a1 = 1'b0;
		sel_a0 = 1'b1;
		pull = 1'b0;
	end
	task automatic hw(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pins(input logic a1, input logic a0);
		mosi_a1 = a1;
		sel_a0 = a0;
		sclk = 1'b1;
		pull = 1'b0;
		hw(8);
	endtask
	// Reply bit is taken just before each rising edge, since the device moved it after the last
	task automatic spi(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = '0;
		sel_a0 = 1'b0;
		for (int i = 0; i < n; i++) begin
			mosi_a1 = tx[15 - i];
			hw(4);
			rx = {rx[14:0], line};
			sclk = 1'b1;
			hw(4);
			sclk = 1'b0;
		end
		sel_a0 = 1'b1;
		// A released data line does not keep its last bit
		mosi_a1 = !mosi_a1;
		hw(6);
	endtask
	task automatic bit_x(input logic b, output logic s);
		hw(1);
		pull = !b;
		hw(3);
		sclk = 1'b1;
		hw(4);
		s = line;
		sclk = 1'b0;
	endtask
	task automatic xbyte(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
		output logic nak);
		for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
		bit_x(ack, nak);
	endtask
	// Releases, then waits out a pending acknowledge before raising the clock, or its release would look like a stop
	task automatic i2c_start();
		pull = 1'b0;
		hw(6);
		sclk = 1'b1;
		hw(4);
		pull = 1'b1;
		hw(4);
		sclk = 1'b0;
	endtask
	task automatic i2c_stop();
		pull = 1'b1;
		hw(4);
		sclk = 1'b1;
		hw(4);
		pull = 1'b0;
		hw(6);
	endtask
	task automatic i2c_wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
		output logic [2:0] nak);
		logic [7:0] r;
		i2c_start();
		xbyte({a, 1'b0}, 1'b1, r, nak[2]);
		xbyte(c, 1'b1, r, nak[1]);
		xbyte(d, 1'b1, r, nak[0]);
		i2c_stop();
	endtask
	task automatic i2c_rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d,
		output logic [2:0] nak);
		logic [7:0] r;
		logic k;
		i2c_start();
		xbyte({a, 1'b0}, 1'b1, r, nak[2]);
		xbyte(c, 1'b1, r, nak[1]);
		i2c_start();
		xbyte({a, 1'b1}, 1'b1, r, nak[0]);
		xbyte(8'hFF, 1'b1, d, k);
		i2c_stop();
	endtask
endmodule // serial_host_model
`default_nettype wire

// >>> verilog/delay_port_cfg.svh
`ifndef DELAY_PORT_CFG_SVH
`define DELAY_PORT_CFG_SVH

`define CODE_W 6
`define CODE_RESET 6'h00
`define COLOR_RED_SEL 2'h0
`define COLOR_GREEN_SEL 2'h1
`define COLOR_BLUE_SEL 2'h2
`define COLOR_NONE_SEL 2'h3
`define SPI_CMD_BITS 5'h08
`define SPI_FRAME_BITS 5'h10
`define SPI_FIRST_CODE_BIT 5'h0A
`define SPI_RW_BIT 7
`define I2C_ADDR_BASE 7'h38
`define I2C_LAST_BIT 3'h7
`define I2C_LAST_BYTE 2'h2
`define SYNC_STAGES 2

`endif

// >>> verilog/delay_port_pkg.sv
`include "delay_port_cfg.svh"

package delay_port_pkg;

	typedef logic [`CODE_W-1:0] code_t;

	typedef enum logic [1:0] {
		COLOR_RED = `COLOR_RED_SEL,
		COLOR_GREEN = `COLOR_GREEN_SEL,
		COLOR_BLUE = `COLOR_BLUE_SEL,
		COLOR_NONE = `COLOR_NONE_SEL
	} color_t;

	typedef struct packed {
		code_t red;
		code_t green;
		code_t blue;
	} delay_set_t;

	typedef struct packed {
		logic valid;
		color_t sel;
		code_t code;
	} code_write_t;

	typedef enum logic [2:0] {
		I2C_IDLE = 3'h0,
		I2C_RX = 3'h1,
		I2C_ACK = 3'h3,
		I2C_TX = 3'h2,
		I2C_TX_ACK = 3'h6
	} i2c_state_t;

	// Unused select reads back zero
	function automatic code_t select_code(input delay_set_t codes, input color_t sel);
		code_t c;
		c = '0;
		unique case (sel)
			COLOR_RED: c = codes.red;
			COLOR_GREEN: c = codes.green;
			COLOR_BLUE: c = codes.blue;
			COLOR_NONE: c = '0;
		endcase
		return c;
	endfunction

	// Writes to the unused select are dropped
	function automatic delay_set_t apply_write(input delay_set_t codes, input code_write_t wr);
		delay_set_t d;
		d = codes;
		if (wr.valid) begin
			unique case (wr.sel)
				COLOR_RED: d.red = wr.code;
				COLOR_GREEN: d.green = wr.code;
				COLOR_BLUE: d.blue = wr.code;
				COLOR_NONE: d = codes;
			endcase
		end
		return d;
	endfunction

endpackage

// >>> verilog/dual_serial_delay_code_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "delay_port_cfg.svh"

module dual_serial_delay_code_port (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic serial_protocol_select,
	input wire logic sck_scl,
	input wire logic sdi_addr_select_high,
	input wire logic cs_n_addr_select_low,
	input wire logic sdo_sda_in,
	output logic sdo_sda_out,
	output logic sdo_sda_oe,
	output delay_port_pkg::code_t red_channel_delay,
	output delay_port_pkg::code_t green_channel_delay,
	output delay_port_pkg::code_t blue_channel_delay
);
	// The three codes share one packed carrier; the base leaves the pin bits clear
	if (`CODE_W != 6) begin : g_bad_code_width
		$error("delay code width must be six bits");
	end
	if ((`I2C_ADDR_BASE & 7'h03) != 7'h00) begin : g_bad_addr_base
		$error("address base must leave its two pin bits clear");
	end
	if (`I2C_LAST_BYTE != 2'h2) begin : g_bad_last_byte
		$error("write sequence must end on its third byte");
	end

	// Pin order inside the synchroniser: select, clock, data/high, cs/low, sda
	logic [4:0] pins_q;
	logic [4:0] pins_prev;
	logic spi_mode;
	logic ser_clk;
	logic ser_clk_prev;
	logic sda;
	logic sda_prev;
	logic clk_rise;
	logic clk_fall;
	logic i2c_start;
	logic i2c_stop;
	logic [6:0] own_addr;

	pin_sync #(
		.W(5)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d({serial_protocol_select, sck_scl, sdi_addr_select_high,
			cs_n_addr_select_low, sdo_sda_in}),
		.q(pins_q),
		.prev(pins_prev)
	);

	// A mode change mid-transfer drops the I2C state; SPI restarts at the next select
	assign spi_mode = pins_q[4];
	assign ser_clk = pins_q[3];
	assign ser_clk_prev = pins_prev[3];
	assign sda = pins_q[0];
	assign sda_prev = pins_prev[0];
	// Edges come from synchronised levels, so clock and data keep one latency
	assign clk_rise = ser_clk && !ser_clk_prev;
	assign clk_fall = !ser_clk && ser_clk_prev;
	// Clock high on both samples, so data moving with a clock edge is no start or stop
	assign i2c_start = ser_clk && ser_clk_prev && sda_prev && !sda;
	assign i2c_stop = ser_clk && ser_clk_prev && !sda_prev && sda;
	// Pins supply the two low address bits; the base keeps the upper five
	assign own_addr = {5'(`I2C_ADDR_BASE >> 2), pins_q[2], pins_q[1]};

	delay_port_pkg::delay_set_t delay_r;
	delay_port_pkg::delay_set_t delay_nxt;
	delay_port_pkg::code_write_t spi_wr;
	delay_port_pkg::code_write_t i2c_wr;
	logic spi_sdo;

	spi_frame_engine u_spi (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.active(spi_mode),
		.cs_n(pins_q[1]),
		.sck_rise(clk_rise),
		.sdi(pins_q[2]),
		.codes(delay_r),
		.wr(spi_wr),
		.sdo_bit(spi_sdo)
	);

	// I2C slave
	delay_port_pkg::i2c_state_t st_r;
	delay_port_pkg::i2c_state_t st_nxt;
	logic [2:0] bit_r;
	logic [2:0] bit_nxt;
	logic [7:0] sh_r;
	logic [7:0] sh_nxt;
	logic [1:0] byte_r;
	logic [1:0] byte_nxt;
	logic rw_r;
	logic rw_nxt;
	delay_port_pkg::color_t sel_r;
	delay_port_pkg::color_t sel_nxt;
	logic drive_r;
	logic drive_nxt;
	delay_port_pkg::code_write_t i2c_wr_nxt;
	delay_port_pkg::code_write_t i2c_wr_r;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;

	always_comb begin
		st_nxt = st_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		byte_nxt = byte_r;
		rw_nxt = rw_r;
		sel_nxt = sel_r;
		drive_nxt = drive_r;
		i2c_wr_nxt = '0;
		rx_byte = {sh_r[6:0], sda};
		// Read byte carries the code in its low six bits, upper bits zero
		tx_byte = {2'b00, delay_port_pkg::select_code(delay_r, sel_r)};
		if (spi_mode) begin
			st_nxt = delay_port_pkg::I2C_IDLE;
			drive_nxt = 1'b0;
		end else if (i2c_start) begin
			// A repeated start keeps the color select for the read phase
			st_nxt = delay_port_pkg::I2C_RX;
			bit_nxt = '0;
			byte_nxt = '0;
			drive_nxt = 1'b0;
		end else if (i2c_stop) begin
			st_nxt = delay_port_pkg::I2C_IDLE;
			drive_nxt = 1'b0;
		end else begin
			unique case (st_r)
				delay_port_pkg::I2C_IDLE: begin
					drive_nxt = 1'b0;
				end
				delay_port_pkg::I2C_RX: begin
					if (clk_rise) begin
						sh_nxt = rx_byte;
						bit_nxt = bit_r + 3'h1;
						if (bit_r == `I2C_LAST_BIT) begin
							st_nxt = delay_port_pkg::I2C_ACK;
							if (byte_r == 2'h0) begin
								rw_nxt = rx_byte[0];
								if (rx_byte[7:1] != own_addr) begin
									st_nxt = delay_port_pkg::I2C_IDLE;
								end
							end else if (byte_r == 2'h1) begin
								sel_nxt = delay_port_pkg::color_t'(rx_byte[1:0]);
							end else begin
								i2c_wr_nxt.valid = 1'b1;
								i2c_wr_nxt.sel = sel_r;
								i2c_wr_nxt.code = rx_byte[`CODE_W-1:0];
							end
						end
					end
				end
				delay_port_pkg::I2C_ACK: begin
					if (clk_fall) begin
						// The pull lands about four clocks after the fall; the low phase must be longer
						if (!drive_r) begin
							drive_nxt = 1'b1;
						end else begin
							// Bytes past the third keep writing the same register
							byte_nxt = (byte_r == `I2C_LAST_BYTE) ? byte_r : byte_r + 2'h1;
							bit_nxt = '0;
							if (rw_r) begin
								st_nxt = delay_port_pkg::I2C_TX;
								sh_nxt = tx_byte;
								drive_nxt = !tx_byte[7];
							end else begin
								st_nxt = delay_port_pkg::I2C_RX;
								drive_nxt = 1'b0;
							end
						end
					end
				end
				delay_port_pkg::I2C_TX: begin
					if (clk_rise) begin
						bit_nxt = bit_r + 3'h1;
						if (bit_r == `I2C_LAST_BIT) begin
							st_nxt = delay_port_pkg::I2C_TX_ACK;
						end
					end else if (clk_fall) begin
						sh_nxt = {sh_r[6:0], 1'b0};
						drive_nxt = !sh_r[6];
					end
				end
				delay_port_pkg::I2C_TX_ACK: begin
					// Release for the master's acknowledge, then wait for stop
					if (clk_fall) begin
						drive_nxt = 1'b0;
					end else if (clk_rise) begin
						st_nxt = delay_port_pkg::I2C_IDLE;
					end
				end
				default: begin
					st_nxt = delay_port_pkg::I2C_IDLE;
					drive_nxt = 1'b0;
				end
			endcase
		end
		if (!ce) begin
			st_nxt = st_r;
			bit_nxt = bit_r;
			sh_nxt = sh_r;
			byte_nxt = byte_r;
			rw_nxt = rw_r;
			sel_nxt = sel_r;
			drive_nxt = drive_r;
			i2c_wr_nxt = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= delay_port_pkg::I2C_IDLE;
			bit_r <= '0;
			sh_r <= '0;
			byte_r <= '0;
			rw_r <= 1'b0;
			sel_r <= delay_port_pkg::COLOR_RED;
			drive_r <= 1'b0;
			i2c_wr_r <= '0;
		end else begin
			st_r <= st_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			byte_r <= byte_nxt;
			rw_r <= rw_nxt;
			sel_r <= sel_nxt;
			drive_r <= drive_nxt;
			i2c_wr_r <= i2c_wr_nxt;
		end
	end

	assign i2c_wr = i2c_wr_r;

	// Delay code registers and the shared data pin
	// Only one protocol is live at a time, so the two write ports never collide
	logic pin_out_nxt;
	logic pin_oe_nxt;
	logic pin_out_r;
	logic pin_oe_r;

	always_comb begin
		delay_nxt = delay_r;
		pin_out_nxt = pin_out_r;
		pin_oe_nxt = pin_oe_r;
		if (ce) begin
			delay_nxt = delay_port_pkg::apply_write(delay_r, spi_wr);
			delay_nxt = delay_port_pkg::apply_write(delay_nxt, i2c_wr);
			if (spi_mode) begin
				pin_out_nxt = spi_sdo;
				pin_oe_nxt = !pins_q[1];
			end else begin
				// Open drain: only ever pulls low
				pin_out_nxt = 1'b0;
				pin_oe_nxt = drive_r;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			delay_r <= {`CODE_RESET, `CODE_RESET, `CODE_RESET};
			pin_out_r <= 1'b0;
			pin_oe_r <= 1'b0;
		end else begin
			delay_r <= delay_nxt;
			pin_out_r <= pin_out_nxt;
			pin_oe_r <= pin_oe_nxt;
		end
	end

	assign sdo_sda_out = pin_out_r;
	assign sdo_sda_oe = pin_oe_r;
	assign red_channel_delay = delay_r.red;
	assign green_channel_delay = delay_r.green;
	assign blue_channel_delay = delay_r.blue;
endmodule // dual_serial_delay_code_port

`default_nettype wire

// >>> verilog/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; prev is a third stage for edge finding
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic [W-1:0] prev
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;
	logic [W-1:0] prev_r;
	logic [W-1:0] prev_nxt;

	// A zero-width synchroniser has nothing to carry
	if (W < 1) begin : g_bad_width
		$error("pin_sync width must be at least 1");
	end

	always_comb begin
		meta_nxt = ce ? d : meta_r;
		q_nxt = ce ? meta_r : q_r;
		prev_nxt = ce ? q_r : prev_r;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= '0;
			q_r <= '0;
			prev_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_r <= q_nxt;
			prev_r <= prev_nxt;
		end
	end

	assign q = q_r;
	assign prev = prev_r;
endmodule // pin_sync

`default_nettype wire

// >>> verilog/spi_frame_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "delay_port_cfg.svh"

module spi_frame_engine (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic active,
	input wire logic cs_n,
	input wire logic sck_rise,
	input wire logic sdi,
	input wire delay_port_pkg::delay_set_t codes,
	output delay_port_pkg::code_write_t wr,
	output logic sdo_bit
);
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic [7:0] sh_r;
	logic [7:0] sh_nxt;
	logic [7:0] cmd_r;
	logic [7:0] cmd_nxt;
	logic sdo_r;
	logic sdo_nxt;
	delay_port_pkg::code_write_t wr_r;
	delay_port_pkg::code_write_t wr_nxt;
	delay_port_pkg::code_t rd_code;

	always_comb begin
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		cmd_nxt = cmd_r;
		sdo_nxt = sdo_r;
		wr_nxt = '0;
		rd_code = '0;
		if (!active || cs_n) begin
			// Frame ends with chip select; a short frame leaves nothing behind
			cnt_nxt = '0;
			sdo_nxt = 1'b0;
		end else if (sck_rise && cnt_r != `SPI_FRAME_BITS) begin
			sh_nxt = {sh_r[6:0], sdi};
			cnt_nxt = cnt_r + 5'h01;
			if (cnt_nxt == `SPI_CMD_BITS) begin
				cmd_nxt = sh_nxt;
			end
			if (cnt_nxt == `SPI_FRAME_BITS && !cmd_r[`SPI_RW_BIT]) begin
				wr_nxt.valid = 1'b1;
				wr_nxt.sel = delay_port_pkg::color_t'(cmd_r[1:0]);
				wr_nxt.code = sh_nxt[`CODE_W-1:0];
			end
			// Bit for the next rising edge; two leading data bits are don't-care
			rd_code = delay_port_pkg::select_code(codes, delay_port_pkg::color_t'(cmd_nxt[1:0]));
			if (cmd_nxt[`SPI_RW_BIT] && cnt_nxt >= `SPI_FIRST_CODE_BIT
				&& cnt_nxt < `SPI_FRAME_BITS) begin
				sdo_nxt = rd_code[3'(`SPI_FRAME_BITS - 5'h01 - cnt_nxt)];
			end else begin
				sdo_nxt = 1'b0;
			end
		end
		if (!ce) begin
			cnt_nxt = cnt_r;
			sh_nxt = sh_r;
			cmd_nxt = cmd_r;
			sdo_nxt = sdo_r;
			wr_nxt = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= '0;
			sh_r <= '0;
			cmd_r <= '0;
			sdo_r <= 1'b0;
			wr_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			cmd_r <= cmd_nxt;
			sdo_r <= sdo_nxt;
			wr_r <= wr_nxt;
		end
	end

	assign wr = wr_r;
	assign sdo_bit = sdo_r;
endmodule // spi_frame_engine

`default_nettype wire
